/* File: rtl/flash_range_params.svh */
// Purpose: Named constants for the flash range and protect block
// Assumes: Included by the block's design file and testbench
// Notes:   Offsets are byte addresses in the 16-bit data space
`ifndef FLASH_RANGE_PARAMS_SVH
`define FLASH_RANGE_PARAMS_SVH

// ============================================================
// Register offsets
`define ADDR_PTR_LOW 16'hffa4
`define ADDR_PTR_HIGH 16'hffa5
`define ADDR_RANGE_HIGH 16'hffa6
`define ADDR_RANGE_LOW 16'hffa7
`define ADDR_WRITE_BUF 16'hffa8
`define ADDR_PROTECT_BYTE 16'h0081

// ============================================================
// Reset values
`define RANGE_RESET 8'h00
`define WBUF_RESET 8'h00
`define PTR_RESET 12'h000
`define READ_IDLE 8'h00

// ============================================================
// Field layout
`define HIGH_ADDR_MSB 3
`define SEL_MSB 6
`define SEL_LSB 2
`define PROTECT_FIXED_ONES 8'h83

// ============================================================
// Selector codes and block limits
`define SEL_NONE 5'h1f
`define SEL_FOUR_BASE 4'h7
`define SEL_EIGHT_BASE 3'h3
`define SEL_SIXTEEN_BASE 2'h1
`define TOP_BLOCK_ALL 4'hf

// ============================================================
// Command codes of the sequencer
`define CMD_BLOCK_ERASE 3'h3
`define CMD_BYTE_WRITE 3'h5

`endif

/* File: rtl/flash_range_pkg.sv */
// Purpose: Types shared by the flash range and protect block
// Assumes: Constants come from flash_range_params.svh
// Notes:   Holds types only
package flash_range_pkg;

  // ==========================================================
  // Block count variant, caught from a strap after reset
  typedef enum logic [1:0] {
    VARIANT_FOUR,
    VARIANT_EIGHT,
    VARIANT_SIXTEEN,
    VARIANT_RESERVED
  } variant_t;

  // ==========================================================
  // Protect setup phase
  typedef enum logic {
    PHASE_LATCH,
    PHASE_RUN
  } phase_t;

endpackage

/* File: rtl/flash_range_protect.sv */
// Purpose: Range-end compare, write buffer, pointer counters and
//          block protect check of the flash self-programming unit
// Assumes: One 50 MHz clock, synchronous low reset, CPU data bus
// Notes:   Protect boundary is taken once after each reset
//
// What this block does
// (R1) Range-compare registers give the sequencer's end address; low is last.
// (R2) Both range registers reset to zero, at FFA6H and FFA7H, 8-bit RW.
// (R3) Software keeps upper bits 7..4 of pointer and compare high zero.
// (R4) Software loads compare high with the target block number.
// (R5) Software sets compare low to 00H for erase, FFH for blank check.
// (R6) Eight-bit write buffer holds the byte to program, reset to zero.
// (R7) Protect byte at 0081H; bits 6..2 form the selector.
// (R8) Protection applies only in self-programming mode; blocked ops do nothing.
// (R9) Four-block part: 01110 guards 3..0, 01111 guards 1..0, 11111 none.
// (R10) Eight-block part: 01100..01111 guard 7,5,3,1 down to 0.
// (R11) Sixteen-block part: 01000..01111 guard 15..1 odd down to 0.
// (R12) Idle pointer counters increment until they equal the compare registers.
// (R13) Erase into a protected area sets the write/erase protect error flag.
// (R14) Prohibited selector guards all blocks; boundary latched once after reset.
`timescale 1ns/10ps
`include "flash_range_params.svh"

module flash_range_protect (
  input wire logic clock,
  input wire logic nrst,
  input wire logic [15:0] regAddr,
  input wire logic [7:0] regWrData,
  input wire logic regWrEn,
  input wire logic regRdEn,
  output logic [7:0] regRdData,
  input wire logic [7:0] protectByte,
  input wire logic [1:0] variantStrap,
  input wire logic selfProgMode,
  input wire logic cmdBusy,
  input wire logic cmdStart,
  input wire logic [2:0] cmdCode,
  input wire logic errClear,
  output logic cmdGo,
  output logic writeEraseProtectError,
  output logic [11:0] startPointer,
  output logic [11:0] rangeEndAddr,
  output logic [7:0] writeData
);

  // ==========================================================
  // Register state
  logic [7:0] rangeHigh_q, rangeHigh_d;
  logic [7:0] rangeLow_q, rangeLow_d;
  logic [7:0] writeBuf_q, writeBuf_d;
  logic [7:0] ptrHigh_q, ptrHigh_d;
  logic [7:0] ptrLow_q, ptrLow_d;
  logic [7:0] rdData_q, rdData_d;
  logic [11:0] endAddr_q, endAddr_d;
  logic [11:0] ptrAddr;
  logic [11:0] ptrNext;
  logic ptrWrite;

  // Decoded strobes for each register
  logic wrPtrLow, wrPtrHigh, wrRangeHigh, wrRangeLow, wrWriteBuf;

  assign wrPtrLow = regWrEn && (regAddr == `ADDR_PTR_LOW);
  assign wrPtrHigh = regWrEn && (regAddr == `ADDR_PTR_HIGH);
  assign wrRangeHigh = regWrEn && (regAddr == `ADDR_RANGE_HIGH);
  assign wrRangeLow = regWrEn && (regAddr == `ADDR_RANGE_LOW);
  assign wrWriteBuf = regWrEn && (regAddr == `ADDR_WRITE_BUF);
  assign ptrWrite = wrPtrLow || wrPtrHigh;
  assign ptrAddr = {ptrHigh_q[`HIGH_ADDR_MSB:0], ptrLow_q};
  assign ptrNext = ptrAddr + 12'h001;

  // ==========================================================
  // Protect state
  flash_range_pkg::phase_t phase_q, phase_d;
  flash_range_pkg::variant_t variant_q, variant_d;
  logic [3:0] protTop_q, protTop_d;
  logic protNone_q, protNone_d;
  logic cmdGo_q, cmdGo_d;
  logic protErr_q, protErr_d;
  logic [4:0] sel;
  logic [3:0] decTop;
  logic decNone;
  logic [3:0] cmdBlock;
  logic isModify;
  logic hitProtected;

  // Selector sits between the fixed-one bits
  assign sel = protectByte[`SEL_MSB:`SEL_LSB]; // [R7]

  // ----------------------------------------------------------
  // Selector decode: top guarded block per variant; odd codes
  // fall to the all-guarded case, safer than trusting them
  always_comb begin
    decNone = 1'b0;
    decTop = `TOP_BLOCK_ALL; // [R14]
    // Reserved strap never opens blocks, whatever the selector says
    if (sel == `SEL_NONE &&
        variant_q != flash_range_pkg::VARIANT_RESERVED) begin
      decNone = 1'b1; // [R9] [R10] [R11]
    end else begin
      unique case (variant_q)
        flash_range_pkg::VARIANT_FOUR: begin
          if (sel[4:1] == `SEL_FOUR_BASE) begin
            decTop = {2'b00, ~sel[0], 1'b1}; // [R9]
          end
        end
        flash_range_pkg::VARIANT_EIGHT: begin
          if (sel[4:2] == `SEL_EIGHT_BASE) begin
            decTop = {1'b0, ~sel[1:0], 1'b1}; // [R10]
          end
        end
        flash_range_pkg::VARIANT_SIXTEEN: begin
          if (sel[4:3] == `SEL_SIXTEEN_BASE) begin
            decTop = {~sel[2:0], 1'b1}; // [R11]
          end
        end
        default: begin
          decTop = `TOP_BLOCK_ALL;
        end
      endcase
    end
  end

  // ----------------------------------------------------------
  // Block under attack is the pointer's high address nibble
  assign cmdBlock = ptrHigh_q[`HIGH_ADDR_MSB:0];
  assign isModify = (cmdCode == `CMD_BLOCK_ERASE) ||
                    (cmdCode == `CMD_BYTE_WRITE);
  // Only self-programming mode guards blocks
  assign hitProtected = selfProgMode && isModify && !protNone_q &&
                        (cmdBlock <= protTop_q); // [R8]

  // ==========================================================
  // Register file next values
  always_comb begin
    rangeHigh_d = rangeHigh_q;
    rangeLow_d = rangeLow_q;
    writeBuf_d = writeBuf_q;
    ptrHigh_d = ptrHigh_q;
    ptrLow_d = ptrLow_q;
    rdData_d = `READ_IDLE;
    if (wrRangeHigh) begin
      rangeHigh_d = regWrData; // [R2]
    end
    if (wrRangeLow) begin
      rangeLow_d = regWrData; // [R2]
    end
    if (wrWriteBuf) begin
      writeBuf_d = regWrData; // [R6]
    end
    // Software load beats counting so reloads are never lost
    if (ptrWrite) begin
      if (wrPtrHigh) begin
        ptrHigh_d = regWrData;
      end
      if (wrPtrLow) begin
        ptrLow_d = regWrData;
      end
    end else if (!cmdBusy && (ptrAddr != endAddr_q)) begin
      ptrHigh_d = {ptrHigh_q[7:4], ptrNext[11:8]}; // [R12]
      ptrLow_d = ptrNext[7:0]; // [R12]
    end
    if (regRdEn) begin
      unique case (regAddr)
        `ADDR_PTR_LOW: rdData_d = ptrLow_q;
        `ADDR_PTR_HIGH: rdData_d = ptrHigh_q;
        `ADDR_RANGE_HIGH: rdData_d = rangeHigh_q;
        `ADDR_RANGE_LOW: rdData_d = rangeLow_q;
        `ADDR_WRITE_BUF: rdData_d = writeBuf_q;
        `ADDR_PROTECT_BYTE: rdData_d = protectByte | `PROTECT_FIXED_ONES;
        default: rdData_d = `READ_IDLE;
      endcase
    end
    // Upper nibble is expected clear, so only the low one counts
    endAddr_d = {rangeHigh_q[`HIGH_ADDR_MSB:0], rangeLow_q}; // [R1] [R3]
  end

  // Register file flops; pointers come up zero rather than random
  always_ff @(posedge clock) begin
    if (!nrst) begin
      rangeHigh_q <= `RANGE_RESET;
      rangeLow_q <= `RANGE_RESET;
      writeBuf_q <= `WBUF_RESET;
      ptrHigh_q <= `RANGE_RESET;
      ptrLow_q <= `RANGE_RESET;
      rdData_q <= `READ_IDLE;
      endAddr_q <= `PTR_RESET;
    end else begin
      rangeHigh_q <= rangeHigh_d;
      rangeLow_q <= rangeLow_d;
      writeBuf_q <= writeBuf_d;
      ptrHigh_q <= ptrHigh_d;
      ptrLow_q <= ptrLow_d;
      rdData_q <= rdData_d;
      endAddr_q <= endAddr_d;
    end
  end

  // ==========================================================
  // Protect control next values
  always_comb begin
    phase_d = phase_q;
    variant_d = variant_q;
    protTop_d = protTop_q;
    protNone_d = protNone_q;
    cmdGo_d = 1'b0;
    protErr_d = protErr_q;
    unique case (phase_q)
      // First cycle: catch strap; second: catch boundary
      flash_range_pkg::PHASE_LATCH: begin
        variant_d = flash_range_pkg::variant_t'(variantStrap);
        protTop_d = decTop; // [R14]
        protNone_d = decNone;
        if (variant_q == flash_range_pkg::variant_t'(variantStrap)) begin
          phase_d = flash_range_pkg::PHASE_RUN;
        end
      end
      flash_range_pkg::PHASE_RUN: begin
        if (cmdStart) begin
          cmdGo_d = !hitProtected; // [R8]
        end
      end
    endcase
    // Set beats clear so a same-cycle hit is kept
    if (errClear) begin
      protErr_d = 1'b0;
    end
    if (cmdStart && hitProtected &&
        phase_q == flash_range_pkg::PHASE_RUN) begin
      protErr_d = 1'b1; // [R13]
    end
  end

  // Protect control flops; reset starts fully guarded
  always_ff @(posedge clock) begin
    if (!nrst) begin
      phase_q <= flash_range_pkg::PHASE_LATCH;
      variant_q <= flash_range_pkg::VARIANT_RESERVED;
      protTop_q <= `TOP_BLOCK_ALL;
      protNone_q <= 1'b0;
      cmdGo_q <= 1'b0;
      protErr_q <= 1'b0;
    end else begin
      phase_q <= phase_d;
      variant_q <= variant_d;
      protTop_q <= protTop_d;
      protNone_q <= protNone_d;
      cmdGo_q <= cmdGo_d;
      protErr_q <= protErr_d;
    end
  end

  // ==========================================================
  // Outputs, all straight from flops
  assign regRdData = rdData_q;
  assign cmdGo = cmdGo_q;
  assign writeEraseProtectError = protErr_q;
  assign startPointer = ptrAddr;
  assign rangeEndAddr = endAddr_q;
  assign writeData = writeBuf_q;

  // ==========================================================
  // Checks
  chk_range_reset_zero: assert property ( // [R2]
    @(posedge clock) !nrst |=> (rangeHigh_q == 8'h00) &&
      (rangeLow_q == 8'h00))
    else $error("range registers not cleared by reset");

  chk_wbuf_load: assert property ( // [R6]
    @(posedge clock) disable iff (!nrst)
    wrWriteBuf |=> writeData == $past(regWrData))
    else $error("write buffer did not take the written byte");

  chk_end_addr_track: assert property ( // [R1]
    @(posedge clock) disable iff (!nrst)
    (wrRangeLow && !wrRangeHigh) |=> ##1
      rangeEndAddr[7:0] == $past(regWrData, 2))
    else $error("end address does not follow the low compare");

  chk_blocked_no_go: assert property ( // [R8]
    @(posedge clock) disable iff (!nrst)
    (phase_q == flash_range_pkg::PHASE_RUN && cmdStart && hitProtected)
      |=> !cmdGo && writeEraseProtectError)
    else $error("protected block modify was let through");

  chk_outside_mode_go: assert property ( // [R8]
    @(posedge clock) disable iff (!nrst)
    (phase_q == flash_range_pkg::PHASE_RUN && cmdStart && !selfProgMode)
      |=> cmdGo)
    else $error("command blocked outside self-programming mode");

  chk_err_sticky: assert property ( // [R13]
    @(posedge clock) disable iff (!nrst)
    (writeEraseProtectError && !errClear) |=> writeEraseProtectError)
    else $error("protect error flag dropped without a clear");

  chk_ptr_count_up: assert property ( // [R12]
    @(posedge clock) disable iff (!nrst)
    (!ptrWrite && !cmdBusy && startPointer != rangeEndAddr)
      |=> startPointer == $past(startPointer) + 12'h001)
    else $error("idle pointer failed to advance");

  chk_ptr_hold_end: assert property ( // [R12]
    @(posedge clock) disable iff (!nrst)
    (!ptrWrite && (cmdBusy || startPointer == rangeEndAddr))
      |=> $stable(startPointer))
    else $error("pointer moved at its end or while busy");

  chk_boundary_frozen: assert property ( // [R14]
    @(posedge clock) disable iff (!nrst)
    phase_q == flash_range_pkg::PHASE_RUN |=>
      $stable(protTop_q) && $stable(protNone_q))
    else $error("protect boundary changed after latching");

  chk_none_all_open: assert property ( // [R9] [R10] [R11]
    @(posedge clock) disable iff (!nrst)
    (phase_q == flash_range_pkg::PHASE_RUN && protNone_q && cmdStart)
      |=> cmdGo)
    else $error("selector 11111 still blocked a command");

endmodule

/* File: tb/tb_flash_range_protect.sv */
// Purpose: Self-checking bench for the flash range and protect block
// Assumes: Design honours the hand-over timing; one clock at 50 MHz
// Notes:   Protect rows reset the block, since the boundary latches once
`timescale 1ns/10ps
`include "flash_range_params.svh"

module tb_flash_range_protect;
  // ==========================================================
  // Stimulus and observed signals
  logic clock = 1'b0;
  logic nrst = 1'b0;
  logic [15:0] regAddr = 16'h0000;
  logic [7:0] regWrData = 8'h00;
  logic regWrEn = 1'b0;
  logic regRdEn = 1'b0;
  logic [7:0] regRdData;
  logic [7:0] protectByte = 8'hff;
  logic [1:0] variantStrap = 2'h0;
  logic selfProgMode = 1'b0;
  logic cmdBusy = 1'b1;
  logic cmdStart = 1'b0;
  logic [2:0] cmdCode = 3'h0;
  logic errClear = 1'b0;
  logic cmdGo;
  logic writeEraseProtectError;
  logic [11:0] startPointer;
  logic [11:0] rangeEndAddr;
  logic [7:0] writeData;
  int err_count = 0;
  int num_checks = 0;
  int cycles = 0;
  // Rows: variant, selector, block, command allowed
  logic [11:0] rows [24] = '{
    {2'h0, 5'h0e, 4'h3, 1'b0}, {2'h0, 5'h0e, 4'h0, 1'b0},
    {2'h0, 5'h0f, 4'h1, 1'b0}, {2'h0, 5'h0f, 4'h2, 1'b1},
    {2'h0, 5'h1f, 4'h0, 1'b1}, {2'h1, 5'h0c, 4'h7, 1'b0},
    {2'h1, 5'h0d, 4'h5, 1'b0}, {2'h1, 5'h0d, 4'h6, 1'b1},
    {2'h1, 5'h0e, 4'h4, 1'b1}, {2'h1, 5'h0f, 4'h1, 1'b0},
    {2'h1, 5'h1f, 4'h7, 1'b1}, {2'h2, 5'h08, 4'hf, 1'b0},
    {2'h2, 5'h09, 4'hd, 1'b0}, {2'h2, 5'h09, 4'he, 1'b1},
    {2'h2, 5'h0a, 4'hc, 1'b1}, {2'h2, 5'h0b, 4'h9, 1'b0},
    {2'h2, 5'h0c, 4'h8, 1'b1}, {2'h2, 5'h0d, 4'h5, 1'b0},
    {2'h2, 5'h0e, 4'h4, 1'b1}, {2'h2, 5'h0f, 4'h2, 1'b1},
    {2'h2, 5'h1f, 4'hf, 1'b1}, {2'h2, 5'h00, 4'hf, 1'b0},
    {2'h0, 5'h10, 4'hf, 1'b0}, {2'h3, 5'h1f, 4'hf, 1'b0}
  };

  flash_range_protect flash_range_protect_i (
    .clock(clock),
    .nrst(nrst),
    .regAddr(regAddr),
    .regWrData(regWrData),
    .regWrEn(regWrEn),
    .regRdEn(regRdEn),
    .regRdData(regRdData),
    .protectByte(protectByte),
    .variantStrap(variantStrap),
    .selfProgMode(selfProgMode),
    .cmdBusy(cmdBusy),
    .cmdStart(cmdStart),
    .cmdCode(cmdCode),
    .errClear(errClear),
    .cmdGo(cmdGo),
    .writeEraseProtectError(writeEraseProtectError),
    .startPointer(startPointer),
    .rangeEndAddr(rangeEndAddr),
    .writeData(writeData)
  );

  // ==========================================================
  // Clock and hang guard, ceiling well above the planned run
  always #10 clock = ~clock;
  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      err_count = err_count + 1;
      give_verdict();
    end
  end

  // ==========================================================
  // Shared tasks
  task automatic chk(input logic [11:0] got, input logic [11:0] exp);
    num_checks = num_checks + 1;
    if (got !== exp) begin
      err_count = err_count + 1;
      $display("wrong value at %0t got %h expected %h", $time, got, exp);
    end
  endtask

  // Strap and protect byte change only with reset, as they latch once
  task automatic rst_dut(input logic [1:0] v, input logic [7:0] p);
    @(posedge clock);
    variantStrap <= v;
    protectByte <= p;
    nrst <= 1'b0;
    repeat (3) @(posedge clock);
    nrst <= 1'b1;
    repeat (3) @(posedge clock);
  endtask

  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge clock);
    regAddr <= a;
    regWrData <= d;
    regWrEn <= 1'b1;
    @(posedge clock);
    regWrEn <= 1'b0;
  endtask

  // Read data is registered, so it is looked at just after the next edge
  task automatic rd(input logic [15:0] a, input logic [7:0] exp);
    @(posedge clock);
    regAddr <= a;
    regRdEn <= 1'b1;
    @(posedge clock);
    regRdEn <= 1'b0;
    #1;
    chk({4'h0, regRdData}, {4'h0, exp});
  endtask

  task automatic launch(input logic [2:0] code, input logic mode);
    @(posedge clock);
    cmdStart <= 1'b1;
    cmdCode <= code;
    selfProgMode <= mode;
    @(posedge clock);
    cmdStart <= 1'b0;
    #1;
  endtask

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // ==========================================================
  // Main sequence
  initial begin
    // Protect decode table, one reset per row
    foreach (rows[i]) begin
      rst_dut(rows[i][11:10], {1'b1, rows[i][9:5], 2'h3});
      wr(`ADDR_PTR_HIGH, {4'h0, rows[i][4:1]});
      launch(`CMD_BLOCK_ERASE, 1'b1);
      chk({11'h000, cmdGo}, {11'h000, rows[i][0]});
      chk({11'h000, writeEraseProtectError}, {11'h000, ~rows[i][0]});
    end
    $display("test protect table done");
    // Reset values; fixed protect bits left low on the input on purpose
    rst_dut(2'h0, 8'h3c);
    rd(`ADDR_RANGE_HIGH, 8'h00);
    rd(`ADDR_RANGE_LOW, 8'h00);
    rd(`ADDR_WRITE_BUF, 8'h00);
    chk(rangeEndAddr, 12'h000);
    $display("test reset values done");
    // Register access, read strobe width and unmapped place
    wr(`ADDR_RANGE_HIGH, 8'h05);
    wr(`ADDR_RANGE_LOW, 8'hff);
    wr(`ADDR_WRITE_BUF, 8'ha5);
    rd(`ADDR_RANGE_HIGH, 8'h05);
    rd(`ADDR_RANGE_LOW, 8'hff);
    rd(`ADDR_WRITE_BUF, 8'ha5);
    @(posedge clock);
    #1;
    chk({4'h0, regRdData}, 12'h000);
    chk(rangeEndAddr, 12'h5ff);
    chk({4'h0, writeData}, 12'h0a5);
    rd(16'h1234, 8'h00);
    rd(`ADDR_PROTECT_BYTE, 8'hbf);
    $display("test register access done");
    // Pointers freeze while busy, then count up to the range end
    wr(`ADDR_PTR_LOW, 8'hfa);
    wr(`ADDR_PTR_HIGH, 8'h05);
    repeat (3) @(posedge clock);
    #1;
    chk(startPointer, 12'h5fa);
    @(posedge clock);
    cmdBusy <= 1'b0;
    repeat (2) @(posedge clock);
    #1;
    chk(startPointer, 12'h5fc);
    repeat (10) @(posedge clock);
    #1;
    chk(startPointer, 12'h5ff);
    @(posedge clock);
    cmdBusy <= 1'b1;
    $display("test pointer count done");
    // Guard only in self-programming mode, and only for erase and write
    wr(`ADDR_PTR_HIGH, 8'h01);
    wr(`ADDR_RANGE_HIGH, 8'h01);
    wr(`ADDR_RANGE_LOW, 8'h00);
    launch(`CMD_BLOCK_ERASE, 1'b0);
    chk({11'h000, cmdGo}, 12'h001);
    wr(`ADDR_RANGE_LOW, 8'hff);
    launch(3'h4, 1'b1);
    chk({11'h000, cmdGo}, 12'h001);
    launch(`CMD_BYTE_WRITE, 1'b1);
    chk({11'h000, cmdGo}, 12'h000);
    repeat (3) @(posedge clock);
    #1;
    chk({11'h000, writeEraseProtectError}, 12'h001);
    @(posedge clock);
    errClear <= 1'b1;
    @(posedge clock);
    errClear <= 1'b0;
    @(posedge clock);
    #1;
    chk({11'h000, writeEraseProtectError}, 12'h000);
    $display("test mode and error flag done");
    give_verdict();
  end
endmodule
